// [sws_pkg.sv]
/*
  Shared constants and types of the standalone watchdog supervisor.
  Assumes a 200 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package sws_pkg;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_PS       = 1000000;  // One timer tick is 1 us.
  localparam int TICK_CYC      = TICK_PS / CLK_PERIOD_PS;
  localparam int TICK_PER_MS   = 1000000000 / TICK_PS;
  localparam int T_SETUP_US    = 150;
  localparam int SETUP_TK      = (T_SETUP_US * 1000000 + TICK_PS - 1) / TICK_PS;

  // ----------------------------------------------------------------
  // Timeouts: the fault trips at the upper end of each window
  // ----------------------------------------------------------------
  localparam int T_LONG_MAX_MS  = 1840;
  localparam int T_SHORT_MAX_MS = 230;
  localparam int LONG_TRIP_TK   = T_LONG_MAX_MS * TICK_PER_MS;
  localparam int SHORT_TRIP_TK  = T_SHORT_MAX_MS * TICK_PER_MS;
  // Capacitor law in us: typ = 77.4 * C[pF] + 55000, trip = typ * 1.095.
  localparam int CAP_SLOPE_X10  = 774;
  localparam int CAP_BASE_MS    = 55;
  localparam int CAP_MAX_PPT    = 1095;
  localparam int CAP_MIN_PF     = 100;
  localparam int CAP_MAX_PF     = 1000000;
  localparam int CAP_RST_PF     = 1000;
  localparam int CAP_W          = 20;
  localparam int CNT_W          = 27;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] A_STATUS   = 8'h00;
  localparam logic [7:0] A_CAP      = 8'h04;
  localparam logic [7:0] A_ELAPSED  = 8'h08;
  localparam logic [7:0] A_TRIP     = 8'h0c;
  localparam logic [7:0] A_IRQ_STAT = 8'h10;
  localparam logic [7:0] A_IRQ_CLR  = 8'h14;
  localparam logic [7:0] A_IRQ_EN   = 8'h18;
  localparam logic [7:0] A_NONE     = 8'hff;
  localparam int IRQ_W       = 3;
  localparam int IRQ_TRIP    = 0;
  localparam int IRQ_RECOVER = 1;
  localparam int IRQ_KICK    = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CFG_OPEN   = 2'b00,
    CFG_PULLUP = 2'b01,
    CFG_CAP    = 2'b10,
    CFG_RSVD   = 2'b11
  } sws_cfg_t;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_LOWV  = 3'b001,
    ST_IDLE  = 3'b010,
    ST_RUN   = 3'b011,
    ST_FAULT = 3'b100
  } sws_state_t;

  typedef struct packed {
    logic aboveOper;
    logic abovePor;
  } sws_supply_t;

  typedef struct packed {
    sws_cfg_t   cfg;
    sws_state_t state;
    logic       setup;
    logic       enMirror;
    logic       fault;
  } sws_status_t;

endpackage

// [sws_top.sv]
/*
  Watchdog supervisor core: kick edge detection, timeout counter, fault
  and enable-mirror outputs, AHB-Lite register slave and interrupt.
  Assumes all pins are synchronous to clk and one slave on the bus.
*/
// Our own choices: register access over AHB-Lite and the register offsets.
// Function
// R1: Between power-on threshold and operating level, pull the fault line low.
// R2: Timely kicks keep the fault line released while enabled.
// R3: No kick within the timeout pulls the fault line low.
// R4: Enable low drives the mirror low and releases the fault line.
// R5: Open config pin selects the long preset, 1840 ms trip.
// R6: Pulled-up config pin selects the short preset, 230 ms trip.
// R7: Capacitor mode typical timeout is 77.4 ms per nF plus 55 ms.
// R8: Capacitor mode trips within 0.905 to 1.095 of typical.
// R9: Capacitor values from 100 pF to 1 uF are supported.
// R10: Host kicks before the minimum timeout since the previous kick.
// R11: Fault asserts when the kick interval exceeds the maximum timeout.
// R12: Resumed timely kicks release the fault line.
// R13: Fault line is open drain, only pulled low or released.
// R14: Only falling kick edges count; rising edges and levels do nothing.
// R15: Disable select low stops the timer and ignores kicks.
// R16: Disable select rising ignores kicks for 150 us setup.
// R17: Enable low stops the timer; monitoring resumes when it returns.
// R18: Each accepted kick restarts the timeout count from zero.
// R19: Config selection is captured once at operating level until power-up; the code recaptures on every ST_LOWV to ST_IDLE step, brownouts included.
`timescale 1ns/100ps
module sws_top import sws_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int LONG_TRIP   = LONG_TRIP_TK,
  parameter int SHORT_TRIP  = SHORT_TRIP_TK,
  parameter int SETUP_TICKS = SETUP_TK
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Supervisor pins
  input  wire sws_supply_t supply,
  input  wire logic        enIn,
  input  wire logic        kickInput,
  input  wire logic        disableSelect,
  input  wire sws_cfg_t    timeoutConfigPin,
  output logic             timeoutFaultNOut,
  output logic             timeoutFaultNOe,
  output logic             enableMirrorOut,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535 || SETUP_TICKS < 1 ||
      SETUP_TICKS > 65535 || LONG_TRIP < 1 || SHORT_TRIP < 1 ||
      LONG_TRIP >= 2**CNT_W || SHORT_TRIP >= 2**CNT_W) begin : g_bad
    $error("sws_top: parameter out of range");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Flip-flops and the combinational signals that feed them
  // ----------------------------------------------------------------
  sws_state_t       state_ff;
  sws_state_t       nxtState;
  sws_cfg_t         cfgMode_ff;
  logic [15:0]      presc_ff;
  logic [15:0]      setupCnt_ff;
  logic [CNT_W-1:0] elapsed_ff;
  logic [CNT_W-1:0] nxt_elapsed;
  logic [CNT_W-1:0] trip_ff;
  logic [CAP_W-1:0] capPf_ff;
  logic [CAP_W-1:0] nxt_capPf;
  logic [IRQ_W-1:0] irqStat_ff;
  logic [IRQ_W-1:0] irqEn_ff;
  logic [IRQ_W-1:0] irqEv;
  logic             kickPrev_ff;
  logic             selPrev_ff;
  logic             faultOe_ff;
  logic             enMirror_ff;
  logic             dWr_ff;
  logic [7:0]       dAddr_ff;

  // ----------------------------------------------------------------
  // Tick, edges and setup window
  // ----------------------------------------------------------------
  // Timing runs on a 1 us tick so counters stay narrow.
  wire tick      = presc_ff == 16'(TICK_CYCLES - 1);
  wire kickFall  = kickPrev_ff & ~kickInput;  // R14
  wire selRise   = disableSelect & ~selPrev_ff;
  wire setupIdle = setupCnt_ff == 16'h0;
  wire monitorOn = enIn & disableSelect;  // R15 R17
  wire stRun     = state_ff == ST_RUN;
  wire stFault   = state_ff == ST_FAULT;
  wire active    = (stRun | stFault) & monitorOn & setupIdle;
  wire kickOk    = active & kickFall;  // R16
  wire tripHit   = elapsed_ff >= trip_ff;

  // Prescaler and setup counter; the setup reload wins over the count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_ff    <= 16'h0;
      setupCnt_ff <= 16'h0;
      kickPrev_ff <= 1'b0;
      selPrev_ff  <= 1'b0;
    end else begin
      presc_ff    <= tick ? 16'h0 : presc_ff + 16'h1;
      kickPrev_ff <= kickInput;
      selPrev_ff  <= disableSelect;
      if (selRise) begin
        setupCnt_ff <= 16'(SETUP_TICKS);  // R16
      end else if (tick && !setupIdle) begin
        setupCnt_ff <= setupCnt_ff - 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Supervisor state machine
  // ----------------------------------------------------------------
  // Supply and disable conditions override the normal flow.
  always_comb begin
    nxtState = state_ff;
    case (state_ff)
      ST_OFF:   nxtState = ST_LOWV;
      ST_LOWV:  nxtState = ST_IDLE;
      ST_IDLE:  if (monitorOn) nxtState = ST_RUN;  // R17
      ST_RUN:   if (active && tripHit && !kickFall) nxtState = ST_FAULT;  // R3 R11
      ST_FAULT: if (kickOk) nxtState = ST_RUN;  // R12
      default:  nxtState = ST_OFF;
    endcase
    if (!supply.abovePor) begin
      nxtState = ST_OFF;
    end else if (!supply.aboveOper) begin
      nxtState = ST_LOWV;  // R1
    end else if (state_ff != ST_OFF && state_ff != ST_LOWV && !monitorOn) begin
      nxtState = ST_IDLE;  // R4 R15 R17
    end
  end

  // Elapsed time since the last accepted kick; holds once tripped.
  always_comb begin
    nxt_elapsed = elapsed_ff;
    if (!active || kickOk) begin
      nxt_elapsed = '0;  // R18
    end else if (tick && stRun && !tripHit) begin
      nxt_elapsed = elapsed_ff + 1'b1;
    end
  end

  // Trip point for each configuration; only capacitor mode computes it from the capacitor value.
  wire [39:0] capTypUs = 40'(capPf_ff) * 40'(CAP_SLOPE_X10) / 40'ha
                         + 40'(CAP_BASE_MS * 1000);  // R7
  wire [39:0] capMaxUs = capTypUs * 40'(CAP_MAX_PPT) / 40'h3e8;  // R8
  wire [CNT_W-1:0] cfgTrip =
    (timeoutConfigPin == CFG_CAP)    ? capMaxUs[CNT_W-1:0] :
    (timeoutConfigPin == CFG_PULLUP) ? CNT_W'(SHORT_TRIP) :  // R6
                                       CNT_W'(LONG_TRIP);    // R5
  wire capture = (state_ff == ST_LOWV) && (nxtState == ST_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_OFF;
      elapsed_ff  <= '0;
      cfgMode_ff  <= CFG_OPEN;
      trip_ff     <= CNT_W'(LONG_TRIP);
      faultOe_ff  <= 1'b0;
      enMirror_ff <= 1'b0;
    end else begin
      state_ff    <= nxtState;
      elapsed_ff  <= nxt_elapsed;
      faultOe_ff  <= nxtState == ST_LOWV || nxtState == ST_FAULT;  // R1 R2 R3
      enMirror_ff <= supply.aboveOper & enIn;  // R4
      if (capture) begin
        cfgMode_ff <= timeoutConfigPin;  // R19
        trip_ff    <= cfgTrip;
      end
    end
  end

  // The line is only ever pulled low; the board pull-up makes it high.
  assign timeoutFaultNOut = 1'b0;  // R13
  assign timeoutFaultNOe  = faultOe_ff;
  assign enableMirrorOut  = enMirror_ff;

  a_lowv_fault: assert property ((supply.abovePor && !supply.aboveOper) |=> timeoutFaultNOe)
    else $error("fault line not held low below operating level");  // R1
  a_en_release: assert property ((!enIn && supply.aboveOper && supply.abovePor)
    |=> (!enableMirrorOut && !timeoutFaultNOe)) else $error("enable low not honoured");  // R4
  a_trip_fault: assert property ((stRun && active && tripHit && !kickFall && supply.aboveOper)
    |=> (timeoutFaultNOe && state_ff == ST_FAULT)) else $error("missed timeout fault");  // R3
  a_kick_recover: assert property ((stFault && kickOk && supply.aboveOper)
    |=> (!timeoutFaultNOe && elapsed_ff == '0)) else $error("kick did not recover");  // R12
  a_only_falling: assert property ((elapsed_ff != '0) ##1 (elapsed_ff == '0)
    |-> ($past(kickFall) || !$past(active))) else $error("count cleared without kick");  // R14
  a_sel_off: assert property ((!disableSelect && supply.aboveOper && supply.abovePor)
    |=> (state_ff == ST_IDLE && !timeoutFaultNOe)) else $error("select low not idle");  // R15
  a_setup_hold: assert property ($rose(disableSelect) |=> (elapsed_ff == '0)[*3])
    else $error("kicks not ignored during setup");  // R16
  a_cfg_held: assert property ((state_ff != ST_LOWV) |=> ($stable(cfgMode_ff)
    && $stable(trip_ff))) else $error("config changed after capture");  // R19
  a_preset_trip: assert property ((state_ff == ST_RUN && cfgMode_ff == CFG_PULLUP)
    |-> trip_ff == CNT_W'(SHORT_TRIP)) else $error("wrong short preset");  // R6
  a_long_trip: assert property ((state_ff == ST_RUN && cfgMode_ff == CFG_OPEN)
    |-> trip_ff == CNT_W'(LONG_TRIP)) else $error("wrong long preset");  // R5
  c_fault_seen:   cover property (stRun ##1 stFault);
  c_recovered:    cover property (stFault ##1 stRun);
  c_setup_done:   cover property (!setupIdle ##1 setupIdle);
  c_irq_raised:   cover property ($rose(irq));

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Reads mux the register flops by the data-phase address, so a read
  // right after a write already sees the written value.
  wire addrPhase = hsel & hready & htrans[1];
  wire mapped    = haddr[31:8] == 24'h0;
  wire capWr     = dWr_ff && dAddr_ff == A_CAP;
  wire clrWr     = dWr_ff && dAddr_ff == A_IRQ_CLR;
  wire enWr      = dWr_ff && dAddr_ff == A_IRQ_EN;
  wire sws_status_t status = '{cfg: cfgMode_ff, state: state_ff, setup: !setupIdle,
                               enMirror: enMirror_ff, fault: faultOe_ff};

  // Out-of-range capacitor values are clamped to the supported span.
  assign nxt_capPf =
    (hwdata < 32'(CAP_MIN_PF)) ? CAP_W'(CAP_MIN_PF) :
    (hwdata > 32'(CAP_MAX_PF)) ? CAP_W'(CAP_MAX_PF) :
                                 hwdata[CAP_W-1:0];  // R9

  assign hrdata =
    (dAddr_ff == A_STATUS)   ? 32'(status) :
    (dAddr_ff == A_CAP)      ? 32'(capPf_ff) :
    (dAddr_ff == A_ELAPSED)  ? 32'(elapsed_ff) :
    (dAddr_ff == A_TRIP)     ? 32'(trip_ff) :
    (dAddr_ff == A_IRQ_STAT) ? 32'(irqStat_ff) :
    (dAddr_ff == A_IRQ_EN)   ? 32'(irqEn_ff) :
                               32'h0;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // Interrupt events: set wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always_comb begin
    irqEv              = '0;
    irqEv[IRQ_TRIP]    = stRun & (nxtState == ST_FAULT);
    irqEv[IRQ_RECOVER] = stFault & (nxtState == ST_RUN);
    irqEv[IRQ_KICK]    = kickOk;
  end
  assign irq = |(irqStat_ff & irqEn_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dWr_ff     <= 1'b0;
      dAddr_ff   <= A_NONE;
      capPf_ff   <= CAP_W'(CAP_RST_PF);
      irqStat_ff <= IRQ_RST;
      irqEn_ff   <= IRQ_RST;
    end else begin
      dWr_ff     <= addrPhase & hwrite;
      dAddr_ff   <= !addrPhase ? dAddr_ff : (mapped ? haddr[7:0] : A_NONE);
      irqStat_ff <= (irqStat_ff & ~(clrWr ? hwdata[IRQ_W-1:0] : IRQ_RST)) | irqEv;
      if (capWr) begin
        capPf_ff <= nxt_capPf;
      end
      if (enWr) begin
        irqEn_ff <= hwdata[IRQ_W-1:0];
      end
    end
  end

  a_cap_range: assert property (capPf_ff >= CAP_W'(CAP_MIN_PF)
    && capPf_ff <= CAP_W'(CAP_MAX_PF)) else $error("capacitor value out of range");  // R9
  a_set_wins: assert property ((irqEv[IRQ_TRIP] && clrWr) |=> irqStat_ff[IRQ_TRIP])
    else $error("trip event lost to clear");

endmodule

// [sws_host_model.sv]
/*
  Host processor model that kicks the watchdog with falling edges.
  Assumes the bench gives it the clock, a run flag and a kick period.
*/
`timescale 1ns/100ps
module sws_host_model (
  // Clock
  input  wire logic        clk,
  // Control from the bench
  input  wire logic        active,
  input  wire logic [15:0] period,
  // Kick line
  output logic             kick
);
  logic [15:0] cnt_ff;

  // One falling edge per period; a stopped host holds the line low, which gives one more falling edge if it stops while high.
  always_ff @(posedge clk) begin
    if (!active || cnt_ff >= period - 16'h1) begin
      cnt_ff <= 16'h0;
    end else begin
      cnt_ff <= cnt_ff + 16'h1;
    end
    kick <= active && (cnt_ff < (period >> 1));
  end
endmodule

// [sws_top_tb_top.sv]
/*
  Self-checking bench of the watchdog supervisor with shortened timeouts.
  Assumes the host model file is compiled first; one AHB-Lite slave.
*/
`timescale 1ns/100ps
module sws_top_tb_top import sws_pkg::*;;
  typedef struct { logic [31:0] m; logic [31:0] e; } sws_exp_t;
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdPend = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic        hreadyout, hresp, enIn = 1'b0, disableSelect = 1'b0, kickInput, active = 1'b0;
  logic        timeoutFaultNOut, timeoutFaultNOe, enableMirrorOut, irq;
  logic [15:0] period = 16'd200;
  sws_supply_t supply = '0;
  sws_cfg_t    cfg = CFG_OPEN;
  sws_exp_t    expQ[$];
  sws_exp_t    ex;
  int          fails = 0, total_checks = 0;
  // The pull-up wins whenever the open-drain pin is released.
  wire         faultPin = timeoutFaultNOe ? timeoutFaultNOut : 1'b1;

  always #2.5 clk = ~clk;

  sws_top #(.TICK_CYCLES(1), .LONG_TRIP(300), .SHORT_TRIP(100), .SETUP_TICKS(4)) dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .supply(supply), .enIn(enIn),
    .kickInput(kickInput), .disableSelect(disableSelect), .timeoutConfigPin(cfg),
    .timeoutFaultNOut(timeoutFaultNOut), .timeoutFaultNOe(timeoutFaultNOe),
    .enableMirrorOut(enableMirrorOut), .irq(irq));

  sws_host_model host (.clk(clk), .active(active), .period(period), .kick(kickInput));

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  // One single AHB-Lite word; a read leaves its expectation for the monitor.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, m, e);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdPend <= !w;
    if (!w) expQ.push_back('{m, e});
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdPend <= 1'b0;
  endtask

  // Read data is compared at the edge that closes the data phase.
  always @(posedge clk) begin
    if (rdPend && hreadyout === 1'b1) begin
      ex = expQ.pop_front();
      check("hrdata", hrdata & ex.m, ex.e);
      check("hresp", {31'h0, hresp}, 32'h0);
    end
  end

  task automatic pins(input int n, input logic f, input logic m);
    repeat (n) @(posedge clk);
    #1;
    check("faultPin", {31'h0, faultPin}, {31'h0, f});
    check("mirror", {31'h0, enableMirrorOut}, {31'h0, m});
  endtask

  // Halts the host right after a kick so the trip is timed from a known edge.
  task automatic stop_kicks();
    @(negedge kickInput);
    @(posedge clk);
    active <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h7269));
    supply <= 2'b01;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    pins(4, 1'b0, 1'b0);
    ahb(1'b0, A_CAP, 32'h0, 32'hffffffff, 32'd1000);
    ahb(1'b0, 8'h40, 32'h0, 32'hffffffff, 32'h0);
    $display("test low supply done");
    // Open pin captured at operating level, host kicks within the window.
    @(posedge clk);
    supply <= 2'b11;
    enIn <= 1'b1;
    disableSelect <= 1'b1;
    active <= 1'b1;
    ahb(1'b1, A_IRQ_EN, 32'h1, 32'h0, 32'h0);
    repeat (6) begin
      period <= 16'($urandom_range(280, 40));
      pins(600, 1'b1, 1'b1);
    end
    ahb(1'b0, A_STATUS, 32'h0, 32'hff, 32'h1a);
    $display("test kicks done");
    // Missing kicks trip the long preset at its maximum.
    period <= 16'd200;
    stop_kicks();
    pins(290, 1'b1, 1'b1);
    pins(30, 1'b0, 1'b1);
    check("irq", {31'h0, irq}, 32'h1);
    ahb(1'b1, A_IRQ_CLR, 32'h1, 32'h0, 32'h0);
    ahb(1'b0, A_IRQ_STAT, 32'h0, 32'h1, 32'h0);
    check("irqClr", {31'h0, irq}, 32'h0);
    active <= 1'b1;
    pins(600, 1'b1, 1'b1);
    $display("test timeout done");
    // Enable low mirrors low, releases the pin and stops the timer while the host is halted.
    @(posedge clk);
    enIn <= 1'b0;
    active <= 1'b0;
    pins(500, 1'b1, 1'b0);
    @(posedge clk);
    enIn <= 1'b1;
    active <= 1'b1;
    pins(400, 1'b1, 1'b1);
    $display("test enable done");
    // Disable select low stops the timer although no kick arrives.
    stop_kicks();
    disableSelect <= 1'b0;
    pins(500, 1'b1, 1'b1);
    @(posedge clk);
    disableSelect <= 1'b1;
    active <= 1'b1;
    pins(400, 1'b1, 1'b1);
    $display("test disable done");
    // New power-up captures the pulled-up pin; later pin changes are ignored.
    @(posedge clk);
    supply <= 2'b00;
    active <= 1'b0;
    repeat (5) @(posedge clk);
    cfg <= CFG_PULLUP;
    supply <= 2'b11;
    active <= 1'b1;
    period <= 16'd80;
    pins(400, 1'b1, 1'b1);
    cfg <= CFG_OPEN;
    ahb(1'b0, A_STATUS, 32'h0, 32'hc0, 32'h40);
    stop_kicks();
    pins(90, 1'b1, 1'b1);
    pins(30, 1'b0, 1'b1);
    $display("test short preset done");
    // Capacitor mode: a too-small value clamps to 100 pF, whose trip is 68.7 ms.
    ahb(1'b1, A_CAP, 32'h5, 32'h0, 32'h0);
    ahb(1'b0, A_CAP, 32'h0, 32'hffffffff, 32'd100);
    @(posedge clk);
    supply <= 2'b00;
    active <= 1'b0;
    repeat (5) @(posedge clk);
    cfg <= CFG_CAP;
    supply <= 2'b11;
    repeat (3) @(posedge clk);
    ahb(1'b0, A_TRIP, 32'h0, 32'hffffffff, 32'd68700);
    ahb(1'b0, A_STATUS, 32'h0, 32'hc0, 32'h80);
    $display("test capacitor done");
    report_and_stop();
  end
endmodule
